// ### cpu_pkg.sv
package cpu_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE      = 8'h0c;
    localparam logic [7:0] IDX_PERIPHERAL_FLAGS_TWO      = 8'h0d;
    localparam logic [7:0] IDX_TIMER1_COUNT_LO   = 8'h0e;
    localparam logic [7:0] IDX_TIMER1_COUNT_HI   = 8'h0f;
    localparam logic [7:0] IDX_T1_CTRL   = 8'h10;
    localparam logic [7:0] IDX_TIMER2_COUNT      = 8'h11;
    localparam logic [7:0] IDX_T2_CTRL   = 8'h12;
    localparam logic [7:0] IDX_U1_LO     = 8'h15;
    localparam logic [7:0] IDX_U1_HI     = 8'h16;
    localparam logic [7:0] IDX_U1_CTRL   = 8'h17;
    localparam logic [7:0] IDX_U2_LO     = 8'h1b;
    localparam logic [7:0] IDX_U2_HI     = 8'h1c;
    localparam logic [7:0] IDX_U2_CTRL   = 8'h1d;
    localparam logic [7:0] IDX_PORTC_DIR = 8'h87;
    localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE      = 8'h8c;
    localparam logic [7:0] IDX_PERIPHERAL_ENABLES_TWO      = 8'h8d;
    localparam logic [7:0] IDX_TIMER2_COUNT_PER  = 8'h92;
    localparam logic [7:0] IDX_ADC_CTRL  = 8'h1f;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         PERIPHERAL_FLAGS_ONE_TIMER1_COUNT_BIT  = 0;
    localparam int         PERIPHERAL_FLAGS_ONE_TIMER2_COUNT_BIT  = 1;
    localparam int         PERIPHERAL_FLAGS_ONE_UNIT_BIT  = 2;
    localparam int         PERIPHERAL_FLAGS_TWO_UNIT_BIT  = 0;
    localparam int         T1_ON_BIT      = 0;
    localparam int         T2_ON_BIT      = 2;
    localparam int         ADC_ON_BIT     = 0;
    localparam int         UNIT_PIN_BIT   = 2;
    localparam logic [7:0] RST_ZERO       = 8'h00;
    localparam logic [7:0] RST_PORTC_DIR  = 8'hff;
    localparam logic [7:0] RST_TIMER2_COUNT_PER   = 8'hff;
    localparam logic [7:0] CTRL_MASK      = 8'h3f;
    localparam logic [7:0] T2_CTRL_MASK   = 8'h7f;

    // ------------------------------------------------------------
    // Mode field encodings
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_SET_PIN   = 4'h8;
    localparam logic [3:0] MODE_CLR_PIN   = 4'h9;
    localparam logic [3:0] MODE_FLAG_ONLY = 4'ha;
    localparam logic [3:0] MODE_SPECIAL   = 4'hb;

    // Per-unit control register layout
    typedef struct packed {
        logic [1:0] unused;
        logic       duty_bit1;
        logic       duty_bit0;
        logic [3:0] mode_field;
    } cpu_ctrl_t;

    // Per-unit event bundle
    typedef struct packed {
        logic match;
        logic special;
        logic period_end;
    } cpu_evt_t;

endpackage

// ### cpu_compare_pwm.sv
// Notes on behaviour
// - Compare mode: match value to timer1 count, pin set, cleared or kept per mode.
// - Every compare match sets the unit interrupt flag in the same cycle.
// - Control register written zero forces compare output latch low.
// - Flag-only mode leaves the pin alone and just raises the flag.
// - Unit 1 special event clears timer1 count on match.
// - Unit 2 special event clears timer1 and starts conversion if converter enabled.
// - Build option: unit 1 special event also starts conversion on single-unit part.
// - Special-event timer1 clear never sets the timer1 overflow flag.
// - PWM mode drives the pin with up to 10-bit duty resolution.
// - Control register written zero forces PWM output latch low.
// - PWM period comes from the timer2 period register.
// - At period match timer2 clears, pin sets unless duty zero, duty copied.
// - Timer2 postscaler only makes the update-rate flag, not the PWM period.
// - Duty is low-byte register on top, control bits 5:4 below.
// - New duty takes effect only after the next period match.
// - In PWM mode the value high byte ignores software writes.
// - Pin clears when buffered duty equals timer2 extended by 2 low bits.
// - Duty above the period never clears the pin: output stays high.
// - Mode field: 0 off, 8 set, 9 clear, a flag, b special, 11xx PWM.
//
// Design decision made here: register access over APB.
module cpu_compare_pwm #(
    parameter bit SINGLE_UNIT = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Unit pins and conversion start
    output logic      [1:0]  unit_pin_o,
    output logic      [1:0]  unit_pin_oe_o,
    output logic             adc_start_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  peripheral_flags_one_reg, peripheral_flags_one_next, peripheral_enables_one_reg, peripheral_enables_one_next;
    logic        peripheral_flags_two_reg, peripheral_flags_two_next, peripheral_enables_two_reg, peripheral_enables_two_next;
    logic [15:0] timer1_count_reg, timer1_count_next;
    logic [7:0]  t1ctl_reg, t1ctl_next, timer2_count_reg, timer2_count_next;
    logic [7:0]  t2ctl_reg, t2ctl_next, per_reg, per_next;
    logic [7:0]  dir_reg, dir_next, adc_reg, adc_next;
    logic [3:0]  t2pre_reg, t2pre_next, post_reg, post_next;
    logic [7:0]  vlo_reg [2], vlo_next [2];
    logic [7:0]  vhi_reg [2], vhi_next [2];
    logic [1:0]  lat2_reg [2], lat2_next [2];
    cpu_pkg::cpu_ctrl_t ctl_reg [2], ctl_next [2];
    logic [1:0]  out_reg, out_next;
    logic [31:0] rd_reg, rd_next;
    logic        rdy_reg, rdy_next, err_reg, err_next, adst_reg, adst_next;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic       wr, acc;
    logic [7:0] idx, wd;
    assign acc = psel_i & penable_i & ~rdy_reg;
    assign wr  = acc & pwrite_i;
    assign idx = paddr_i[9:2];
    assign wd  = pwdata_i[7:0];

    // ------------------------------------------------------------
    // Per-unit compare and PWM events
    // ------------------------------------------------------------
    logic [1:0]  is_pwm, cmp_match, special, pwm_clr;
    logic [1:0]  t2_sub;
    logic        t2_tick, per_hit;
    logic [9:0]  t2_ext, t2_ext_inc;
    // Prescaler bits extend timer2; a prescale of one uses a free 2-bit phase
    assign t2_sub  = t2pre_reg[1:0];
    assign t2_ext  = {timer2_count_reg, t2_sub};
    // One step ahead: the pin latch adds a cycle, so high time equals duty
    assign t2_ext_inc = t2_ext + 10'h001;
    assign t2_tick = t2ctl_reg[cpu_pkg::T2_ON_BIT] &
                     (t2ctl_reg[1] ? (t2pre_reg == 4'hf) :
                      t2ctl_reg[0] ? (t2pre_reg[1:0] == 2'h3) : 1'b1);
    assign per_hit = t2_tick & (timer2_count_reg == per_reg);

    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_unit
            assign is_pwm[u]    = ctl_reg[u].mode_field[3:2] == 2'b11;
            assign cmp_match[u] = (ctl_reg[u].mode_field[3:2] == 2'b10) &
                                  (timer1_count_reg == {vhi_reg[u], vlo_reg[u]});
            assign special[u]   = cmp_match[u] &
                                  (ctl_reg[u].mode_field == cpu_pkg::MODE_SPECIAL);
            // Duty above period never equals the extended count
            assign pwm_clr[u]   = is_pwm[u] & ({vhi_reg[u], lat2_reg[u]} == t2_ext_inc);
        end
    endgenerate

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rv;
        logic       t1_wr;
        rv         = 8'h00;
        t1_wr      = 1'b0;
        peripheral_flags_one_next  = peripheral_flags_one_reg;
        peripheral_flags_two_next  = peripheral_flags_two_reg;
        peripheral_enables_one_next  = peripheral_enables_one_reg;
        peripheral_enables_two_next  = peripheral_enables_two_reg;
        t1ctl_next = t1ctl_reg;
        t2ctl_next = t2ctl_reg;
        per_next   = per_reg;
        dir_next   = dir_reg;
        adc_next   = adc_reg;
        timer1_count_next  = timer1_count_reg;
        timer2_count_next  = timer2_count_reg;
        t2pre_next = t2pre_reg;
        post_next  = post_reg;
        out_next   = out_reg;
        adst_next  = 1'b0;
        for (int i = 0; i < 2; i++) begin
            vlo_next[i]  = vlo_reg[i];
            vhi_next[i]  = vhi_reg[i];
            lat2_next[i] = lat2_reg[i];
            ctl_next[i]  = ctl_reg[i];
        end

        // Software writes first; hardware events below override flags
        if (wr) begin
            case (idx)
                cpu_pkg::IDX_PERIPHERAL_FLAGS_ONE:      peripheral_flags_one_next  = wd;
                cpu_pkg::IDX_PERIPHERAL_FLAGS_TWO:      peripheral_flags_two_next  = wd[cpu_pkg::PERIPHERAL_FLAGS_TWO_UNIT_BIT];
                cpu_pkg::IDX_PERIPHERAL_ENABLES_ONE:      peripheral_enables_one_next  = wd;
                cpu_pkg::IDX_PERIPHERAL_ENABLES_TWO:      peripheral_enables_two_next  = wd[cpu_pkg::PERIPHERAL_FLAGS_TWO_UNIT_BIT];
                cpu_pkg::IDX_TIMER1_COUNT_LO:   begin timer1_count_next[7:0] = wd; t1_wr = 1'b1; end
                cpu_pkg::IDX_TIMER1_COUNT_HI:   begin timer1_count_next[15:8] = wd; t1_wr = 1'b1; end
                cpu_pkg::IDX_T1_CTRL:   t1ctl_next = wd & cpu_pkg::CTRL_MASK;
                cpu_pkg::IDX_TIMER2_COUNT:      timer2_count_next  = wd;
                cpu_pkg::IDX_T2_CTRL:   t2ctl_next = wd & cpu_pkg::T2_CTRL_MASK;
                cpu_pkg::IDX_TIMER2_COUNT_PER:  per_next   = wd;
                cpu_pkg::IDX_PORTC_DIR: dir_next   = wd;
                cpu_pkg::IDX_ADC_CTRL:  adc_next   = wd;
                cpu_pkg::IDX_U1_LO:     vlo_next[0] = wd;
                cpu_pkg::IDX_U2_LO:     vlo_next[1] = wd;
                cpu_pkg::IDX_U1_HI:     if (!is_pwm[0]) vhi_next[0] = wd;
                cpu_pkg::IDX_U2_HI:     if (!is_pwm[1]) vhi_next[1] = wd;
                cpu_pkg::IDX_U1_CTRL:   ctl_next[0] = wd & cpu_pkg::CTRL_MASK;
                cpu_pkg::IDX_U2_CTRL:   ctl_next[1] = wd & cpu_pkg::CTRL_MASK;
                default:                ;
            endcase
        end

        // Timer1: free count, software write, or special-event clear
        if (|special) begin
            timer1_count_next = 16'h0000;
        end else if (!t1_wr && t1ctl_reg[cpu_pkg::T1_ON_BIT]) begin
            timer1_count_next = timer1_count_reg + 16'h0001;
            if (timer1_count_reg == 16'hffff) begin
                peripheral_flags_one_next[cpu_pkg::PERIPHERAL_FLAGS_ONE_TIMER1_COUNT_BIT] = 1'b1;
            end
        end

        // Conversion start from unit 2, or unit 1 on the single-unit build
        if ((special[1] | (SINGLE_UNIT & special[0])) &
            adc_reg[cpu_pkg::ADC_ON_BIT]) begin
            adst_next = 1'b1;
        end

        // Timer2 prescaler and count
        if (t2ctl_reg[cpu_pkg::T2_ON_BIT]) begin
            t2pre_next = t2pre_reg + 4'h1;
        end
        if (per_hit) begin
            timer2_count_next = 8'h00;
            // Postscaler feeds only the update-rate flag
            post_next = post_reg + 4'h1;
            if (post_reg == t2ctl_reg[6:3]) begin
                post_next = 4'h0;
                peripheral_flags_one_next[cpu_pkg::PERIPHERAL_FLAGS_ONE_TIMER2_COUNT_BIT] = 1'b1;
            end
        end else if (t2_tick) begin
            timer2_count_next = timer2_count_reg + 8'h01;
        end

        // Unit pin latches and flags
        for (int i = 0; i < 2; i++) begin
            if (cmp_match[i]) begin
                if (i == 0) peripheral_flags_one_next[cpu_pkg::PERIPHERAL_FLAGS_ONE_UNIT_BIT] = 1'b1;
                else        peripheral_flags_two_next = 1'b1;
                if (ctl_reg[i].mode_field == cpu_pkg::MODE_SET_PIN) out_next[i] = 1'b1;
                if (ctl_reg[i].mode_field == cpu_pkg::MODE_CLR_PIN) out_next[i] = 1'b0;
            end
            if (is_pwm[i]) begin
                if (pwm_clr[i]) out_next[i] = 1'b0;
                if (per_hit) begin
                    // Double buffer loads only here, so no mid-period glitch
                    vhi_next[i]  = vlo_reg[i];
                    lat2_next[i] = {ctl_reg[i].duty_bit1, ctl_reg[i].duty_bit0};
                    out_next[i]  = |{vlo_reg[i], ctl_reg[i].duty_bit1,
                                     ctl_reg[i].duty_bit0};
                end
            end
            if (wr && (idx == (i == 0 ? cpu_pkg::IDX_U1_CTRL : cpu_pkg::IDX_U2_CTRL))
                && wd == 8'h00) begin
                out_next[i] = 1'b0;
            end
        end

        // Read mux
        case (idx)
            cpu_pkg::IDX_PERIPHERAL_FLAGS_ONE:      rv = peripheral_flags_one_reg;
            cpu_pkg::IDX_PERIPHERAL_FLAGS_TWO:      rv = {7'h00, peripheral_flags_two_reg};
            cpu_pkg::IDX_PERIPHERAL_ENABLES_ONE:      rv = peripheral_enables_one_reg;
            cpu_pkg::IDX_PERIPHERAL_ENABLES_TWO:      rv = {7'h00, peripheral_enables_two_reg};
            cpu_pkg::IDX_TIMER1_COUNT_LO:   rv = timer1_count_reg[7:0];
            cpu_pkg::IDX_TIMER1_COUNT_HI:   rv = timer1_count_reg[15:8];
            cpu_pkg::IDX_T1_CTRL:   rv = t1ctl_reg;
            cpu_pkg::IDX_TIMER2_COUNT:      rv = timer2_count_reg;
            cpu_pkg::IDX_T2_CTRL:   rv = t2ctl_reg;
            cpu_pkg::IDX_TIMER2_COUNT_PER:  rv = per_reg;
            cpu_pkg::IDX_PORTC_DIR: rv = dir_reg;
            cpu_pkg::IDX_ADC_CTRL:  rv = adc_reg;
            cpu_pkg::IDX_U1_LO:     rv = vlo_reg[0];
            cpu_pkg::IDX_U1_HI:     rv = vhi_reg[0];
            cpu_pkg::IDX_U1_CTRL:   rv = ctl_reg[0];
            cpu_pkg::IDX_U2_LO:     rv = vlo_reg[1];
            cpu_pkg::IDX_U2_HI:     rv = vhi_reg[1];
            cpu_pkg::IDX_U2_CTRL:   rv = ctl_reg[1];
            default:                rv = 8'h00;
        endcase
        rdy_next = acc;
        err_next = acc & (paddr_i[11:10] != 2'b00 || paddr_i[1:0] != 2'b00);
        rd_next  = (acc && !pwrite_i) ? {24'h000000, rv} : rd_reg;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            peripheral_flags_one_reg  <= cpu_pkg::RST_ZERO;
            peripheral_enables_one_reg  <= cpu_pkg::RST_ZERO;
            peripheral_flags_two_reg  <= 1'b0;
            peripheral_enables_two_reg  <= 1'b0;
            timer1_count_reg  <= 16'h0000;
            t1ctl_reg <= cpu_pkg::RST_ZERO;
            timer2_count_reg  <= cpu_pkg::RST_ZERO;
            t2ctl_reg <= cpu_pkg::RST_ZERO;
            per_reg   <= cpu_pkg::RST_TIMER2_COUNT_PER;
            dir_reg   <= cpu_pkg::RST_PORTC_DIR;
            adc_reg   <= cpu_pkg::RST_ZERO;
            t2pre_reg <= 4'h0;
            post_reg  <= 4'h0;
            out_reg   <= 2'b00;
            rd_reg    <= 32'h00000000;
            rdy_reg   <= 1'b0;
            err_reg   <= 1'b0;
            adst_reg  <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                vlo_reg[i]  <= cpu_pkg::RST_ZERO;
                vhi_reg[i]  <= cpu_pkg::RST_ZERO;
                lat2_reg[i] <= 2'b00;
                ctl_reg[i]  <= cpu_pkg::RST_ZERO;
            end
        end else begin
            peripheral_flags_one_reg  <= peripheral_flags_one_next;
            peripheral_enables_one_reg  <= peripheral_enables_one_next;
            peripheral_flags_two_reg  <= peripheral_flags_two_next;
            peripheral_enables_two_reg  <= peripheral_enables_two_next;
            timer1_count_reg  <= timer1_count_next;
            t1ctl_reg <= t1ctl_next;
            timer2_count_reg  <= timer2_count_next;
            t2ctl_reg <= t2ctl_next;
            per_reg   <= per_next;
            dir_reg   <= dir_next;
            adc_reg   <= adc_next;
            t2pre_reg <= t2pre_next;
            post_reg  <= post_next;
            out_reg   <= out_next;
            rd_reg    <= rd_next;
            rdy_reg   <= rdy_next;
            err_reg   <= err_next;
            adst_reg  <= adst_next;
            for (int i = 0; i < 2; i++) begin
                vlo_reg[i]  <= vlo_next[i];
                vhi_reg[i]  <= vhi_next[i];
                lat2_reg[i] <= lat2_next[i];
                ctl_reg[i]  <= ctl_next[i];
            end
        end
    end

    // Outputs; enable is a register so the pins are flop driven
    logic [1:0] oe_reg;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) oe_reg <= 2'b00;
        else         oe_reg <= {~dir_next[1], ~dir_next[cpu_pkg::UNIT_PIN_BIT]};
    end
    assign unit_pin_o    = out_reg;
    assign unit_pin_oe_o = oe_reg;
    assign prdata_o      = rd_reg;
    assign pready_o      = rdy_reg;
    assign pslverr_o     = err_reg;
    assign adc_start_o   = adst_reg;

endmodule

// ### cpu_compare_pwm_props.sv
// ------------------------------------------------------------
// Port-level checker for the compare/PWM block
// ------------------------------------------------------------
module cpu_compare_pwm_props #(
    parameter bit SINGLE_UNIT = 1'b0
) (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    // APB slave side
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Pins and conversion start
    input wire logic [1:0]  unit_pin_o,
    input wire logic [1:0]  unit_pin_oe_o,
    input wire logic        adc_start_o
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] U1_CTRL_ADDR = {2'b00, cpu_pkg::IDX_U1_CTRL, 2'b00};
    localparam logic [11:0] U2_CTRL_ADDR = {2'b00, cpu_pkg::IDX_U2_CTRL, 2'b00};

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Access taken in its first access cycle
    logic taken;
    assign taken = psel_i && penable_i && !pready_o;

    AST_RDY_LATENCY: assert property (taken |=> pready_o)
        else $error("pready did not follow the access cycle");
    AST_RDY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    AST_RDY_CAUSE: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("pready without an access");
    AST_ERR_ALIGN: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    AST_ERR_MISALIGN: assert property (taken && paddr_i[1:0] != 2'b00 |=> pslverr_o)
        else $error("misaligned access not refused");
    AST_RDATA_HIGH: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_CTRL0_PIN1: assert property (taken && pwrite_i && paddr_i == U1_CTRL_ADDR
        && pwdata_i[7:0] == 8'h00 |-> ##[1:3] !unit_pin_o[0])
        else $error("unit 1 pin not low after control cleared");
    AST_CTRL0_PIN2: assert property (taken && pwrite_i && paddr_i == U2_CTRL_ADDR
        && pwdata_i[7:0] == 8'h00 |-> ##[1:3] !unit_pin_o[1])
        else $error("unit 2 pin not low after control cleared");
    AST_ADC_PULSE: assert property (adc_start_o |=> !adc_start_o)
        else $error("conversion start longer than one cycle");
endmodule

bind cpu_compare_pwm cpu_compare_pwm_props #(.SINGLE_UNIT(SINGLE_UNIT)) u_props (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .unit_pin_o(unit_pin_o),
    .unit_pin_oe_o(unit_pin_oe_o), .adc_start_o(adc_start_o)
);

// ### cpu_pin_load.sv
// ------------------------------------------------------------
// Load on the unit pin: pull-down, counts high cycles
// ------------------------------------------------------------
module cpu_pin_load (
    // Clock
    input  wire logic ref_clk_i,
    // Pin and its enable
    input  wire logic pin_i,
    input  wire logic oe_i,
    // Running count of high cycles
    output int        high_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic line;
    // Undriven pin is pulled low, so a lost enable shows up as duty loss
    assign line = oe_i ? pin_i : 1'b0;
    initial high_cnt_o = 0;
    always @(posedge ref_clk_i) begin
        if (line === 1'b1) high_cnt_o <= high_cnt_o + 1;
    end
endmodule

// ### cpu_compare_pwm_tb.sv
module cpu_compare_pwm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, adc_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  pin, pin_oe;
    logic [7:0]  q;
    logic        e;
    int          n_mismatch, checks_done, hc, h0, adc_cnt, a0;
    logic [7:0]  rv_idx [0:7] = '{8'h0c, 8'h10, 8'h17, 8'h1d, 8'h87, 8'h8c, 8'h92, 8'h12};
    logic [7:0]  rv_val [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
    logic [3:0]  c_mode [0:3] = '{4'h8, 4'ha, 4'h9, 4'h8};
    logic [7:0]  d_lo [0:3] = '{8'h04, 8'h02, 8'hff, 8'h00};
    logic [1:0]  d_lsb [0:3] = '{2'b00, 2'b11, 2'b00, 2'b00};
    int          d_hi [0:3] = '{16, 11, 32, 0};

    cpu_compare_pwm u_cpu_compare_pwm (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .unit_pin_o(pin), .unit_pin_oe_o(pin_oe),
        .adc_start_o(adc_start)
    );
    cpu_pin_load u_cpu_pin_load (.ref_clk_i(ref_clk_i), .pin_i(pin[0]), .oe_i(pin_oe[0]),
        .high_cnt_o(hc));

    // ------------------------------------------------------------
    // Bus tasks and comparisons
    // ------------------------------------------------------------
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge ref_clk_i);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge ref_clk_i);
        penable <= 1'b1;
        n = 0;
        // Bounded wait: a missing pready must not hang the run
        do begin @(posedge ref_clk_i); n++; end while (pready !== 1'b1 && n < 20);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) n_mismatch++;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d); apb({2'b0, i, 2'b0}, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] i); apb({2'b0, i, 2'b0}, 1'b0, 8'h00);
    endtask
    task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
        checks_done++;
        if (g !== x) begin n_mismatch++; $display("ERROR %s exp %h got %h", s, x, g); end
    endtask
    task automatic chk_n(input string s, input int x, input int g);
        checks_done++;
        if (g != x) begin n_mismatch++; $display("ERROR %s exp %0d got %0d", s, x, g); end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t1_restart;
        wr(cpu_pkg::IDX_T1_CTRL, 8'h00);
        wr(cpu_pkg::IDX_TIMER1_COUNT_LO, 8'h00);
        wr(cpu_pkg::IDX_TIMER1_COUNT_HI, 8'h00);
        wr(cpu_pkg::IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
        wr(cpu_pkg::IDX_PERIPHERAL_FLAGS_TWO, 8'h00);
    endtask

    initial begin ref_clk_i = 1'b0; forever #5 ref_clk_i = ~ref_clk_i; end
    always @(posedge ref_clk_i) if (adc_start === 1'b1) adc_cnt++;
    // Watchdog sized well above the few thousand cycles the tests need
    initial begin #200us; n_mismatch++; close_out(); end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nrst_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; n_mismatch = 0; checks_done = 0; adc_cnt = 0;
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin rd(rv_idx[i]); chk("reset_val", rv_val[i], q); end
        rd(8'h40); chk("unmapped", 8'h00, q);
        apb(12'h055, 1'b0, 8'h00); chk("slverr", 8'h01, {7'h0, e});
        // Compare actions: set, flag only, clear, set again
        wr(cpu_pkg::IDX_PORTC_DIR, 8'hf9);
        wr(cpu_pkg::IDX_U1_LO, 8'h20);
        wr(cpu_pkg::IDX_U1_HI, 8'h00);
        wr(cpu_pkg::IDX_U2_LO, 8'h20);
        for (int i = 0; i < 4; i++) begin
            t1_restart();
            wr(cpu_pkg::IDX_U1_CTRL, {4'h0, c_mode[i]});
            wr(cpu_pkg::IDX_U2_CTRL, {4'h0, c_mode[i]});
            wr(cpu_pkg::IDX_T1_CTRL, 8'h01);
            repeat (60) @(posedge ref_clk_i);
            chk("pin1", {7'h0, c_mode[i] != 4'h9}, {7'h0, pin[0]});
            chk("pin2", {7'h0, c_mode[i] != 4'h9}, {7'h0, pin[1]});
            rd(cpu_pkg::IDX_PERIPHERAL_FLAGS_ONE); chk("flag1", 8'h04, q & 8'h04);
            rd(cpu_pkg::IDX_PERIPHERAL_FLAGS_TWO); chk("flag2_cmp", 8'h01, q & 8'h01);
        end
        // Clearing control first is also the safe way to change modes
        wr(cpu_pkg::IDX_U1_CTRL, 8'h00);
        wr(cpu_pkg::IDX_U2_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk_i);
        chk("pin1_off", 8'h00, {7'h0, pin[0]});
        chk("pin2_off", 8'h00, {7'h0, pin[1]});
        // Special event of unit 2 with converter on and off
        t1_restart();
        wr(cpu_pkg::IDX_U2_LO, 8'h30);
        wr(cpu_pkg::IDX_U2_HI, 8'h00);
        wr(cpu_pkg::IDX_ADC_CTRL, 8'h01);
        wr(cpu_pkg::IDX_U2_CTRL, {4'h0, cpu_pkg::MODE_SPECIAL});
        wr(cpu_pkg::IDX_T1_CTRL, 8'h01);
        // Long enough that a missing clear would carry into the high byte
        for (int i = 0; i < 8; i++) begin
            repeat (37) @(posedge ref_clk_i);
            rd(cpu_pkg::IDX_TIMER1_COUNT_HI); chk("t1_hi", 8'h00, q);
        end
        chk_n("adc_on", 1, int'(adc_cnt >= 3));
        rd(cpu_pkg::IDX_PERIPHERAL_FLAGS_ONE); chk("t1_ovf", 8'h00, q & 8'h01);
        rd(cpu_pkg::IDX_PERIPHERAL_FLAGS_TWO); chk("flag2", 8'h01, q & 8'h01);
        wr(cpu_pkg::IDX_ADC_CTRL, 8'h00);
        a0 = adc_cnt;
        repeat (150) @(posedge ref_clk_i);
        chk_n("adc_off", a0, adc_cnt);
        // Unit 1 special event: timer cleared, no conversion on two-unit build
        wr(cpu_pkg::IDX_U2_CTRL, 8'h00);
        wr(cpu_pkg::IDX_ADC_CTRL, 8'h01);
        wr(cpu_pkg::IDX_U1_CTRL, {4'h0, cpu_pkg::MODE_SPECIAL});
        a0 = adc_cnt;
        repeat (300) @(posedge ref_clk_i);
        chk_n("adc_u1", a0, adc_cnt);
        rd(cpu_pkg::IDX_TIMER1_COUNT_HI); chk("t1_hi_u1", 8'h00, q);
        wr(cpu_pkg::IDX_U1_CTRL, 8'h00);
        // PWM: period 8 timer steps of 4 clocks, postscaler set to its maximum
        wr(cpu_pkg::IDX_TIMER2_COUNT_PER, 8'h07);
        wr(cpu_pkg::IDX_T2_CTRL, 8'h7d);
        for (int i = 0; i < 4; i++) begin
            wr(cpu_pkg::IDX_U1_LO, d_lo[i]);
            wr(cpu_pkg::IDX_U1_CTRL, {2'b00, d_lsb[i], 4'hc});
            repeat (80) @(posedge ref_clk_i);
            h0 = hc;
            repeat (64) @(posedge ref_clk_i);
            chk_n("pwm_high", 2 * d_hi[i], hc - h0);
            wr(cpu_pkg::IDX_U1_HI, 8'h55);
            rd(cpu_pkg::IDX_U1_HI); chk("buf_hi", d_lo[i], q);
        end
        // Twenty periods have passed, past the sixteen the postscaler needs, so the update-rate flag is up
        rd(cpu_pkg::IDX_PERIPHERAL_FLAGS_ONE); chk("t2_post", 8'h02, q & 8'h02);
        // Full duty keeps the pin high, so the clear below is visible
        wr(cpu_pkg::IDX_U1_LO, 8'hff);
        wr(cpu_pkg::IDX_U1_CTRL, 8'h0c);
        repeat (80) @(posedge ref_clk_i);
        wr(cpu_pkg::IDX_U1_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk_i);
        chk("pwm_off", 8'h00, {7'h0, pin[0]});
        close_out();
    end
endmodule
